//--- hw/hpas_sampler.sv
// Host port access sampler: oversamples async host strobes, commits writes, drives reads
`timescale 1ns/1ps

// Notes on behaviour
// - Host pins are asynchronous; sample them on every rising internal clock edge.
// - A write is committed only at the first non-access sample after access.
// - Every write-qualifying sample outside a read access captures data, overwriting the earlier capture.
// - First non-access sample does not capture; it commits the last held value.
// - Read drives the bus from first qualifying sample until first non-access.
// - Access needs a strobe together with chip select low, in any order.
// - A sample missing setup is invalid; recognition waits for the next sample.
module hpas_sampler
   import hpas_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst_b,
   input  wire logic              host_chip_select_n,
   input  wire logic              host_write_n,
   input  wire logic              host_read_n,
   input  wire logic [DATA_W-1:0] host_data_in,
   input  wire logic [DATA_W-1:0] rd_data,
   output logic      [DATA_W-1:0] host_data_out,
   output logic      [DATA_W-1:0] host_data_oe,
   output logic                   wr_commit,
   output logic      [DATA_W-1:0] wr_data,
   output logic                   rd_start
);

   logic              cs_n_s1_q;
   logic              cs_n_s2_q;
   logic              wr_n_s1_q;
   logic              wr_n_s2_q;
   logic              rd_n_s1_q;
   logic              rd_n_s2_q;
   logic [DATA_W-1:0] dat_s1_q;
   logic [DATA_W-1:0] dat_s2_q;
   logic [DATA_W-1:0] hold_q;
   logic [DATA_W-1:0] wr_data_q;
   logic              wr_commit_q;
   logic              rd_start_q;
   logic              drive_q;
   logic [DATA_W-1:0] dout_q;
   hpas_state_t       state_q;
   hpas_state_t       state_d;
   logic              wr_cond;
   logic              rd_cond;
   logic              no_access;
   logic              commit_now;

   // Write condition: select low with the write strobe low
   function automatic logic write_seen(input logic cs_n, input logic wr_n);
      return !cs_n && !wr_n;
   endfunction

   // Read condition; write has priority when both strobes are low
   function automatic logic read_seen(input logic cs_n, input logic wr_n, input logic rd_n);
      return !cs_n && !rd_n && wr_n;
   endfunction

   // Non-access: select high, or neither strobe low
   function automatic logic idle_seen(input logic cs_n, input logic wr_n, input logic rd_n);
      return cs_n || (wr_n && rd_n);
   endfunction

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cs_n_s1_q <= 1'b1;
         cs_n_s2_q <= 1'b1;
      end
      else
      begin
         cs_n_s1_q <= host_chip_select_n;
         cs_n_s2_q <= cs_n_s1_q;
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wr_n_s1_q <= 1'b1;
         wr_n_s2_q <= 1'b1;
      end
      else
      begin
         wr_n_s1_q <= host_write_n;
         wr_n_s2_q <= wr_n_s1_q;
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rd_n_s1_q <= 1'b1;
         rd_n_s2_q <= 1'b1;
      end
      else
      begin
         rd_n_s1_q <= host_read_n;
         rd_n_s2_q <= rd_n_s1_q;
      end
   end

   // data kept in step with the strobes, so capture lines up with the condition
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         dat_s1_q <= WR_RESET;
         dat_s2_q <= WR_RESET;
      end
      else
      begin
         dat_s1_q <= host_data_in;
         dat_s2_q <= dat_s1_q;
      end
   end

   // a late-changing input resolves in the synchroniser; the next sample decides
   assign wr_cond    = write_seen(cs_n_s2_q, wr_n_s2_q);
   assign rd_cond    = read_seen(cs_n_s2_q, wr_n_s2_q, rd_n_s2_q);
   assign no_access  = idle_seen(cs_n_s2_q, wr_n_s2_q, rd_n_s2_q);
   assign commit_now = (state_q == HPAS_WRITE) && no_access;

   always_comb
   begin
      state_d = state_q;
      case (state_q)
         HPAS_IDLE:
         begin
            if (wr_cond)
               state_d = HPAS_WRITE;
            else if (rd_cond)
               state_d = HPAS_READ;
         end
         // A swapped strobe without release stays inside the same access
         HPAS_WRITE:
         begin
            if (no_access)
               state_d = HPAS_IDLE;
         end
         HPAS_READ:
         begin
            if (no_access)
               state_d = HPAS_IDLE;
         end
         default:
            state_d = HPAS_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         state_q <= HPAS_IDLE;
      else
         state_q <= state_d;
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         hold_q <= WR_RESET;
      else if (wr_cond && state_q != HPAS_READ)
         hold_q <= dat_s2_q;
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         wr_commit_q <= 1'b0;
      else
         wr_commit_q <= commit_now;
   end

   // no capture then, last value used
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         wr_data_q <= WR_RESET;
      else if (commit_now)
         wr_data_q <= hold_q;
   end

   // drive from first read sample to first non-access
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         drive_q <= 1'b0;
      else
         drive_q <= (state_d == HPAS_READ);
   end

   // Pulse for the internal fetch at the first read sample
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         rd_start_q <= 1'b0;
      else
         rd_start_q <= (state_q == HPAS_IDLE) && (state_d == HPAS_READ);
   end

   // Read data follows the internal source on every read sample
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         dout_q <= RD_RESET;
      else if (state_d == HPAS_READ)
         dout_q <= rd_data;
   end

   // Host side are assumed: short strobes may be missed entirely
   assign host_data_out = dout_q;
   assign host_data_oe  = {DATA_W{drive_q}};
   assign wr_commit     = wr_commit_q;
   assign wr_data       = wr_data_q;
   assign rd_start      = rd_start_q;

endmodule // hpas_sampler

//--- hw/hpas_pkg.sv
// Constants and types for the host port access sampler
package hpas_pkg;
   localparam int unsigned DATA_W       = 16;
   localparam int unsigned CLK_FREQ_MHZ = 20;
   localparam int unsigned MIN_SAMPLES  = 3;
   localparam logic [15:0] RD_RESET     = 16'h0000;
   localparam logic [15:0] WR_RESET     = 16'h0000;

   typedef enum logic [1:0] {
      HPAS_IDLE,
      HPAS_WRITE,
      HPAS_READ
   } hpas_state_t;
endpackage

//--- bench/hpas_props.sv
// Port assertions for the host port access sampler
`timescale 1ns/1ps
module hpas_props import hpas_pkg::*; (input wire logic clk, rst_b, host_chip_select_n, host_write_n,
   host_read_n, wr_commit, rd_start, input wire logic [DATA_W-1:0] host_data_in, rd_data, host_data_out,
   host_data_oe, wr_data);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   chk_commit_on_idle:
   assert property (wr_commit |-> $past(host_chip_select_n | host_write_n, 3)
      && !$past(host_chip_select_n | host_write_n, 4)) else $error("commit not after write end");
   chk_commit_last_data:
   assert property (wr_commit |-> wr_data == $past(host_data_in, 4)) else $error("commit data wrong");
   chk_commit_single:
   assert property (wr_commit |=> !wr_commit) else $error("commit longer than one cycle");
   chk_wdata_held:
   assert property (!wr_commit |-> $stable(wr_data)) else $error("write data moved");
   chk_read_start:
   assert property (rd_start |-> !$past(host_read_n | host_chip_select_n, 2) && host_data_oe == '1)
      else $error("bad read start");
   chk_oe_begin:
   assert property ($rose(host_data_oe[0]) |-> rd_start) else $error("drive without read start");
   chk_oe_release:
   assert property ($fell(host_data_oe[0]) |-> $past(host_read_n | host_chip_select_n, 2))
      else $error("drive dropped early");
   chk_oe_whole_bus:
   assert property (host_data_oe == '0 || host_data_oe == '1) else $error("partial drive");
   chk_read_fresh:
   assert property (rd_start |-> !$past(host_data_oe[0])) else $error("read start inside a read");
endmodule // hpas_props
bind hpas_sampler hpas_props i_hpas_props(.*);

//--- bench/hpas_host_model.sv
// Host CPU model driving the parallel port pins
`timescale 1ns/1ps
module hpas_host_model import hpas_pkg::*; (input wire logic clk, output logic host_chip_select_n,
   output logic host_write_n, output logic host_read_n, output logic [DATA_W-1:0] host_data_in);
   initial {host_chip_select_n, host_write_n, host_read_n, host_data_in} = '1;
   // strobe before select, held n+1 samples
   task automatic access(input logic rd, input logic cs_on, input logic [DATA_W-1:0] d, input int n);
      @(posedge clk);
      if (rd)
         host_read_n <= 1'b0;
      else
         host_write_n <= 1'b0;
      @(posedge clk);
      host_chip_select_n <= !cs_on;
      host_data_in <= ~d;
      @(posedge clk);
      host_data_in <= d;
      repeat (n) @(posedge clk);
      {host_chip_select_n, host_write_n, host_read_n} <= 3'b111;
      // Released bus shows no stale value
      host_data_in <= ~d;
      @(posedge clk);
   endtask
endmodule // hpas_host_model

//--- bench/hpas_sampler_bench.sv
// Self-checking bench for the host port access sampler
`timescale 1ns/1ps
module hpas_sampler_bench;
   import hpas_pkg::*;
   logic clk = 0, rst_b = 0, host_chip_select_n, host_write_n, host_read_n, wr_commit, rd_start;
   logic [15:0] host_data_in, rd_data = '0, host_data_out, host_data_oe, wr_data, last, d, rd_prev = '0;
   logic [31:0] s = 32'h4c2213ab;
   logic rd_sel, cs_sel;
   int errors = 0, num_checks = 0, commits = 0, exp_c = 0, rd_starts = 0, exp_r = 0;
   always #25 clk = ~clk;
   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      return v ^ (v << 5);
   endfunction
   hpas_host_model i_hpas_host_model(
      .clk                (clk),
      .host_chip_select_n (host_chip_select_n),
      .host_write_n       (host_write_n),
      .host_read_n        (host_read_n),
      .host_data_in       (host_data_in)
   );
   hpas_sampler i_hpas_sampler(
      .clk                (clk),
      .rst_b              (rst_b),
      .host_chip_select_n (host_chip_select_n),
      .host_write_n       (host_write_n),
      .host_read_n        (host_read_n),
      .host_data_in       (host_data_in),
      .rd_data            (rd_data),
      .host_data_out      (host_data_out),
      .host_data_oe       (host_data_oe),
      .wr_commit          (wr_commit),
      .wr_data            (wr_data),
      .rd_start           (rd_start)
   );
   always @(posedge clk)
   begin
      s <= xs(s);
      rd_data <= s[15:0];
      rd_prev <= rd_data;
      if (wr_commit === 1'b1)
      begin
         commits <= commits + 1;
         last <= wr_data;
      end
      if (rd_start === 1'b1)
         rd_starts <= rd_starts + 1;
      if (host_data_oe[0] === 1'b1)
         check(host_data_out, rd_prev);
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report;
      $display("errors %0d checks %0d", errors, num_checks);
      if (errors == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      #400000;
      errors++;
      final_report;
   end
   initial
   begin
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      for (int i = 0; i < 40; i++)
      begin
         // Corner cases first: a plain write, then a plain read
         rd_sel = (i < 2) ? (i == 1) : s[20];
         cs_sel = (i < 2) || s[21] || s[22];
         d = s[15:0];
         i_hpas_host_model.access(rd_sel, cs_sel, d, MIN_SAMPLES + i % 3);
         @(posedge clk) #1;
         check(host_data_oe, (rd_sel && cs_sel) ? 16'hffff : 16'h0000);
         repeat (3) @(posedge clk);
         #1;
         if (!rd_sel && cs_sel)
            exp_c++;
         if (rd_sel && cs_sel)
            exp_r++;
         check(commits, exp_c);
         check(rd_starts, exp_r);
         if (!rd_sel && cs_sel)
            check(last, d);
         check(host_data_oe, 16'h0000);
      end
      final_report;
   end
endmodule // hpas_sampler_bench
